// [logic/nsd_nsr_if.sv]
/*
 Link between the top level and one noise-shaping requantizer:
 sample in, configuration, sample out.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface nsd_nsr_if import nsd_pkg::*; #(
	parameter int DATA_W = 16
);
	logic                     in_valid;
	logic signed [DATA_W-1:0] in_data;
	logic                     mode_11;
	logic                     mode_12;
	logic [TUNE_W-1:0]        tune;
	logic                     clr;
	logic                     out_valid;
	logic signed [DATA_W-1:0] out_data;

	modport ctrl (
		output in_valid, in_data, mode_11, mode_12, tune, clr,
		input  out_valid, out_data
	);
	modport nsr (
		input  in_valid, in_data, mode_11, mode_12, tune, clr,
		output out_valid, out_data
	);
endinterface

// [logic/nsd_pkg.sv]
/*
 Shared constants for the requantizer and decimation block: register
 indices, field positions, reset values and filter tuning tables.
 Assumes a 32-bit APB bus whose byte address is four times the index.
*/
package nsd_pkg;

	// Register indices; byte address is the index shifted left by two
	localparam logic [9:0] IDX_TUNE_A = 10'h078;
	localparam logic [9:0] IDX_TUNE_B = 10'h079;
	localparam logic [9:0] IDX_MODE   = 10'h07A;
	localparam logic [9:0] IDX_FIR_A  = 10'h07B;
	localparam logic [9:0] IDX_FIR_B  = 10'h07C;
	localparam logic [9:0] IDX_STATUS = 10'h07D;

	// Field positions
	localparam int TUNE_W       = 7;
	localparam int BIT_NSR_CLR  = 7;
	localparam int BIT_DUAL     = 7;
	localparam int BIT_A_11     = 0;
	localparam int BIT_A_12     = 1;
	localparam int BIT_B_11     = 2;
	localparam int BIT_B_12     = 3;
	localparam int BIT_FIR_A0   = 7;
	localparam int FIR_A_W      = 9;
	localparam int FIR_B_W      = 8;
	localparam int BIT_ILL_A    = 4;
	localparam int BIT_ILL_B    = 5;
	localparam int BIT_MISMATCH = 6;
	localparam int BIT_ST_DUAL  = 7;

	// Values after reset
	localparam logic [TUNE_W-1:0]  RST_TUNE  = 7'h00;
	localparam logic [3:0]         RST_MODE  = 4'h0;
	localparam logic [FIR_A_W-1:0] RST_FIR_A = 9'h000;
	localparam logic [FIR_B_W-1:0] RST_FIR_B = 8'h00;

	// First filter number of each bandwidth group, and the last 12-bit filter number
	localparam logic [TUNE_W-1:0] FLT_11A_FIRST = 7'h00;
	localparam logic [TUNE_W-1:0] FLT_11B_FIRST = 7'h15;
	localparam logic [TUNE_W-1:0] FLT_12A_FIRST = 7'h2A;
	localparam logic [TUNE_W-1:0] FLT_12B_FIRST = 7'h3F;
	localparam logic [TUNE_W-1:0] FLT_12_LAST   = 7'h4C;

	// Centre frequency over fs, unsigned Q0.16: start and step per group
	localparam logic [15:0] CTR_22  = 16'h1EB8;
	localparam logic [15:0] STEP_22 = 16'h02D1;
	localparam logic [15:0] CTR_25  = 16'h2000;
	localparam logic [15:0] STEP_25 = 16'h0333;
	localparam logic [15:0] CTR_29  = 16'h2666;
	localparam logic [15:0] STEP_29 = 16'h0630;

	// Requantized word widths
	localparam int QW_11 = 11;
	localparam int QW_12 = 12;

endpackage

// [logic/nsd_requant.sv]
/*
 One noise-shaping requantizer: second-order error feedback whose noise
 notch sits at the centre frequency picked by the tuning word.
 Assumes configuration is static while samples flow.
*/
`timescale 1ns/1ps
module nsd_requant import nsd_pkg::*; #(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link to the top level
	nsd_nsr_if.nsr   q
);
	localparam int AW = DATA_W + 4;
	localparam int SH11 = DATA_W - QW_11;
	localparam int SH12 = DATA_W - QW_12;
	localparam logic signed [AW-1:0] MASK11 = AW'((1 << SH11) - 1);
	localparam logic signed [AW-1:0] MASK12 = AW'((1 << SH12) - 1);
	localparam logic signed [AW-1:0] MAX_IN = AW'((1 << (DATA_W - 1)) - 1);
	localparam logic signed [AW-1:0] MIN_IN = -AW'(1 << (DATA_W - 1));
	localparam logic signed [19:0]   THREE  = 20'sh30000;
	localparam logic signed [19:0]   HALF_Q = 20'sh10000;

	logic [15:0]              base;
	logic [15:0]              step;
	logic [TUNE_W-1:0]        first;
	logic [22:0]              offs;
	logic [15:0]              freq;
	logic signed [19:0]       x;
	logic signed [39:0]       x_sq;
	logic signed [19:0]       t;
	logic signed [39:0]       xt;
	logic signed [19:0]       coef;
	logic signed [AW+19:0]    fb;
	logic signed [AW-1:0]     v;
	logic signed [AW-1:0]     mask;
	logic signed [AW-1:0]     y_fl;
	logic signed [AW-1:0]     y_sat;
	logic signed [AW-1:0]     hi;
	logic signed [AW-1:0]     e1_reg;
	logic signed [AW-1:0]     e2_reg;
	logic                     active;

	always_comb begin
		if (q.mode_12) begin
			if (q.tune < FLT_12B_FIRST) begin
				base  = CTR_25;
				step  = STEP_25;
				first = FLT_12A_FIRST;
			end else begin
				base  = CTR_29;
				step  = STEP_29;
				first = FLT_12B_FIRST;
			end
		end else if (q.tune < FLT_11B_FIRST) begin
			base  = CTR_22;
			step  = STEP_22;
			first = FLT_11A_FIRST;
		end else begin
			base  = CTR_25;
			step  = STEP_25;
			first = FLT_11B_FIRST;
		end
	end

	assign offs = step * (q.tune - first);
	assign freq = base + offs[15:0];

	// Notch coefficient 2cos(2*pi*f), cubic sine approximation
	assign x    = $signed({2'b00, freq, 2'b00}) - HALF_Q;
	assign x_sq = x * x;
	assign t    = THREE - $signed(x_sq[35:16]);
	assign xt   = x * t;
	assign coef = 20'sh00000 - $signed(xt[35:16]);

	assign active = q.mode_11 | q.mode_12;
	assign mask   = q.mode_12 ? MASK12 : MASK11;
	assign hi     = MAX_IN & ~mask;
	assign fb     = coef * e1_reg;
	assign v      = AW'(q.in_data) + fb[AW+15:16] - e2_reg;
	assign y_fl   = v & ~mask;

	always_comb begin
		if (y_fl > hi) begin
			y_sat = hi;
		end else if (y_fl < MIN_IN) begin
			y_sat = MIN_IN;
		end else begin
			y_sat = y_fl;
		end
	end

	// Residual taken before saturation so the loop stays bounded
	// overload recovery clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			e1_reg <= '0;
			e2_reg <= '0;
		end else if (q.clr || !active) begin
			e1_reg <= '0;
			e2_reg <= '0;
		end else if (q.in_valid) begin
			e1_reg <= v & mask;
			e2_reg <= e1_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.out_valid <= 1'b0;
			q.out_data  <= '0;
		end else begin
			q.out_valid <= q.in_valid;
			if (q.in_valid) begin
				q.out_data <= active ? y_sat[DATA_W-1:0] : q.in_data;
			end
		end
	end
endmodule

// [logic/nsd_top.sv]
/*
 Post-processing top: two noise-shaping requantizers feeding two
 cascaded halving decimation chains, configured over APB.
 Assumes samples arrive synchronous to pclk, tagged with channel.
*/
`timescale 1ns/1ps
// Functional notes
// - 12-bit filters 42-62: 25% band from 0.125; 63-76: 29% from 0.15.
// - Tuning field holds the filter number as plain binary.
// - Both requantizers off: samples pass unchanged.
// - Four enable bits at 0x7A pick 11 or 12 bit per channel.
// - Channel A tuning word, seven bits at 0x78.
// - Channel B tuning word, seven bits at 0x79.
// - Control bit at 0x78 clears requantizer state after overload.
// - Control bit at 0x79 enables dual-channel post-processing.
// - Thermometer stage fields: nine bits A, eight bits B, 0x7A-0x7C.
// - Single mode: B chain off, A chain nine stages, up to 512x.
// - Dual or I/Q mode: both chains active at one rate; code takes each rate from its own stage field.
// - Dual mode tops out at 256x decimation.
// - Enabled requantizer cuts words to 11 or 12 bits.
// - Single uses requantizer A only; dual gives A first, B second.
module nsd_top import nsd_pkg::*; #(
	parameter int DATA_W = 16
) (
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output wire logic                     pready,
	output wire logic [31:0]              prdata,
	output wire logic                     pslverr,
	// Samples from the conversion core
	input  wire logic                     smp_valid,
	input  wire logic                     smp_chan,
	input  wire logic signed [DATA_W-1:0] smp_data,
	// Processed channel A
	output wire logic                     out_a_valid,
	output wire logic signed [DATA_W-1:0] out_a_data,
	// Processed channel B
	output wire logic                     out_b_valid,
	output wire logic signed [DATA_W-1:0] out_b_data
);
	logic [TUNE_W-1:0]  tune_a_reg;
	logic [TUNE_W-1:0]  tune_b_reg;
	logic               dual_postproc_enable;
	logic [3:0]         nsr_mode_reg;
	logic [FIR_A_W-1:0] chan_a_decim_stages;
	logic [FIR_B_W-1:0] chan_b_decim_stages;
	logic               nsr_clr_reg;
	logic [31:0]        prdata_reg;
	logic [31:0]        rdata_next;
	logic               addr_ok;
	logic [9:0]         idx;
	logic               wr_en;
	logic [FIR_A_W-1:0] stg_en [2];
	logic [3:0]         stage_cnt;
	logic               ill_a;
	logic               ill_b;
	logic               mismatch;
	logic [7:0]         status;

	wire logic                     ch_v [2][FIR_A_W+1];
	wire logic signed [DATA_W-1:0] ch_d [2][FIR_A_W+1];

	nsd_nsr_if #(.DATA_W(DATA_W)) nsr_a ();
	nsd_nsr_if #(.DATA_W(DATA_W)) nsr_b ();

	assign idx   = paddr[11:2];
	assign wr_en = psel & penable & pwrite & addr_ok;

	// Address decode and read mux
	always_comb begin
		addr_ok    = 1'b1;
		rdata_next = 32'h0000_0000;
		if (paddr[1:0] != 2'h0) begin
			addr_ok = 1'b0;
		end else if (idx == IDX_TUNE_A) begin
			rdata_next = {25'h0, tune_a_reg};
		end else if (idx == IDX_TUNE_B) begin
			rdata_next = {24'h0, dual_postproc_enable, tune_b_reg};
		end else if (idx == IDX_MODE) begin
			rdata_next = {24'h0, chan_a_decim_stages[0], 3'h0, nsr_mode_reg};
		end else if (idx == IDX_FIR_A) begin
			rdata_next = {24'h0, chan_a_decim_stages[FIR_A_W-1:1]};
		end else if (idx == IDX_FIR_B) begin
			rdata_next = {24'h0, chan_b_decim_stages};
		end else if (idx == IDX_STATUS) begin
			rdata_next = {24'h0, status};
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Read data captured in setup so it is a flop during access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_reg <= rdata_next;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata  = prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune_a_reg <= RST_TUNE;
		end else if (wr_en && idx == IDX_TUNE_A) begin
			tune_a_reg <= pwdata[TUNE_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nsr_clr_reg <= 1'b0;
		end else begin
			nsr_clr_reg <= wr_en && idx == IDX_TUNE_A && pwdata[BIT_NSR_CLR];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tune_b_reg           <= RST_TUNE;
			dual_postproc_enable <= 1'b0;
		end else if (wr_en && idx == IDX_TUNE_B) begin
			tune_b_reg           <= pwdata[TUNE_W-1:0];
			dual_postproc_enable <= pwdata[BIT_DUAL];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nsr_mode_reg        <= RST_MODE;
			chan_a_decim_stages <= RST_FIR_A;
			chan_b_decim_stages <= RST_FIR_B;
		end else if (wr_en && idx == IDX_MODE) begin
			nsr_mode_reg           <= pwdata[3:0];
			chan_a_decim_stages[0] <= pwdata[BIT_FIR_A0];
		end else if (wr_en && idx == IDX_FIR_A) begin
			chan_a_decim_stages[FIR_A_W-1:1] <= pwdata[FIR_A_W-2:0];
		end else if (wr_en && idx == IDX_FIR_B) begin
			chan_b_decim_stages <= pwdata[FIR_B_W-1:0];
		end
	end

	// Tuning word outside its mode's range; both bits set means 12-bit
	always_comb begin
		ill_a = nsr_mode_reg[BIT_A_12] ? (tune_a_reg < FLT_12A_FIRST || tune_a_reg > FLT_12_LAST)
			: (nsr_mode_reg[BIT_A_11] && tune_a_reg >= FLT_12A_FIRST);
		ill_b = nsr_mode_reg[BIT_B_12] ? (tune_b_reg < FLT_12A_FIRST || tune_b_reg > FLT_12_LAST)
			: (nsr_mode_reg[BIT_B_11] && tune_b_reg >= FLT_12A_FIRST);
	end

	// first A stage ignored in dual
	assign stg_en[0] = dual_postproc_enable ? {chan_a_decim_stages[FIR_A_W-1:1], 1'b0}
		: chan_a_decim_stages;
	assign stg_en[1] = dual_postproc_enable ? {1'b0, chan_b_decim_stages} : '0;

	assign mismatch = dual_postproc_enable
		&& (chan_a_decim_stages[FIR_A_W-1:1] != chan_b_decim_stages);

	always_comb begin
		stage_cnt = 4'h0;
		for (int i = 0; i < FIR_A_W; i++) begin
			stage_cnt = stage_cnt + {3'h0, stg_en[0][i]};
		end
	end

	always_comb begin
		status               = {4'h0, stage_cnt};
		status[BIT_ILL_A]    = ill_a;
		status[BIT_ILL_B]    = ill_b;
		status[BIT_MISMATCH] = mismatch;
		status[BIT_ST_DUAL]  = dual_postproc_enable;
	end

	assign nsr_a.in_valid = smp_valid & (~dual_postproc_enable | ~smp_chan);
	assign nsr_b.in_valid = smp_valid & dual_postproc_enable & smp_chan;
	assign nsr_a.in_data  = smp_data;
	assign nsr_b.in_data  = smp_data;
	assign nsr_a.mode_11  = nsr_mode_reg[BIT_A_11];
	assign nsr_a.mode_12  = nsr_mode_reg[BIT_A_12];
	assign nsr_b.mode_11  = nsr_mode_reg[BIT_B_11] & dual_postproc_enable;
	assign nsr_b.mode_12  = nsr_mode_reg[BIT_B_12] & dual_postproc_enable;
	assign nsr_a.tune     = tune_a_reg;
	assign nsr_b.tune     = tune_b_reg;
	assign nsr_a.clr      = nsr_clr_reg;
	assign nsr_b.clr      = nsr_clr_reg;

	nsd_requant #(.DATA_W(DATA_W)) u_nsr_a (
		.clk   (pclk),
		.rst_n (presetn),
		.q     (nsr_a.nsr)
	);

	nsd_requant #(.DATA_W(DATA_W)) u_nsr_b (
		.clk   (pclk),
		.rst_n (presetn),
		.q     (nsr_b.nsr)
	);

	assign ch_v[0][0] = nsr_a.out_valid;
	assign ch_d[0][0] = nsr_a.out_data;
	assign ch_v[1][0] = nsr_b.out_valid;
	assign ch_d[1][0] = nsr_b.out_data;

	// Pair-average halving stages; a cheap stand-in for half-band taps.
	// Disabled stages still register, so latency does not depend on rate.
	for (genvar c = 0; c < 2; c++) begin : g_ch
		for (genvar s = 0; s < FIR_A_W; s++) begin : g_st
			logic signed [DATA_W-1:0] hold_reg;
			logic                     ph_reg;
			logic                     v_reg;
			logic signed [DATA_W-1:0] d_reg;
			logic signed [DATA_W:0]   sum;

			assign sum = {hold_reg[DATA_W-1], hold_reg} + {ch_d[c][s][DATA_W-1], ch_d[c][s]};

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hold_reg <= '0;
					ph_reg   <= 1'b0;
					v_reg    <= 1'b0;
					d_reg    <= '0;
				end else if (!stg_en[c][s]) begin
					ph_reg <= 1'b0;
					v_reg  <= ch_v[c][s];
					if (ch_v[c][s]) begin
						d_reg <= ch_d[c][s];
					end
				end else begin
					v_reg <= 1'b0;
					if (ch_v[c][s] && !ph_reg) begin
						hold_reg <= ch_d[c][s];
						ph_reg   <= 1'b1;
					end else if (ch_v[c][s]) begin
						d_reg  <= sum[DATA_W:1];
						v_reg  <= 1'b1;
						ph_reg <= 1'b0;
					end
				end
			end

			assign ch_v[c][s+1] = v_reg;
			assign ch_d[c][s+1] = d_reg;
		end
	end

	assign out_a_valid = ch_v[0][FIR_A_W];
	assign out_a_data  = ch_d[0][FIR_A_W];
	assign out_b_valid = ch_v[1][FIR_A_W];
	assign out_b_data  = ch_d[1][FIR_A_W];
endmodule

// [tb/nsd_adc_model.sv]
/* Conversion-core model: count samples of 16*i per channel, the second
 channel negated; slow leaves a gap after each. Assumes inputs held while busy. */
`timescale 1ns/1ps
module nsd_adc_model #(
	parameter int DATA_W = 16
) (
	// Control from the bench
	input  wire logic                 pclk, presetn, start, dual, slow,
	input  wire logic [10:0]          count,
	// Sample stream
	output logic                      smp_valid, smp_chan, busy,
	output logic signed [DATA_W-1:0]  smp_data
);
	logic [10:0] left_reg;
	logic [9:0]  idx_reg, i;
	logic        gap_reg;
	assign busy = left_reg != 11'h000;
	assign i    = dual ? idx_reg >> 1 : idx_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_reg  <= 11'h000;
			idx_reg   <= 10'h000;
			gap_reg   <= 1'b0;
			smp_valid <= 1'b0;
			smp_chan  <= 1'b0;
			smp_data  <= '0;
		end else if (start) begin
			left_reg <= count;
			idx_reg  <= 10'h000;
		end else if (busy && !gap_reg) begin
			smp_valid <= 1'b1;
			smp_chan  <= dual & idx_reg[0];
			smp_data  <= (dual & idx_reg[0]) ? -DATA_W'({i, 4'h0}) : DATA_W'({i, 4'h0});
			left_reg  <= left_reg - 11'h001;
			idx_reg   <= idx_reg + 10'h001;
			gap_reg   <= slow;
		end else begin
			smp_valid <= 1'b0;
			// Idle bus toggles so no stale word looks valid
			smp_data  <= ~smp_data;
			gap_reg   <= 1'b0;
		end
	end
endmodule

// [tb/nsd_top_asserts.sv]
/* Port checker for nsd_top.
 Assumes reconfiguration only while the sample path is drained. */
`timescale 1ns/1ps
module nsd_top_asserts import nsd_pkg::*; #(
	parameter int DATA_W = 16
) (
	// Clock, reset and APB
	input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	// Sample stream
	input wire logic                     smp_valid, smp_chan, out_a_valid, out_b_valid,
	input wire logic signed [DATA_W-1:0] smp_data, out_a_data, out_b_data
);
	logic [7:0] cfg [4];
	logic       acc, dual, pass_a, dpass, one_st, q_a;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign acc    = psel && penable;
	assign dual   = cfg[0][7];
	assign pass_a = !dual && cfg[1] == 8'h00 && cfg[2] == 8'h00;
	assign dpass  = dual && cfg[1][3:0] == 4'h0 && cfg[2] == 8'h00 && cfg[3] == 8'h00;
	assign one_st = !dual && cfg[1] == 8'h80 && cfg[2] == 8'h00;
	assign q_a    = out_a_valid && !cfg[1][7] && cfg[2] == 8'h00;
	// Shadow of mode and stage registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cfg <= '{default: 8'h00};
		else if (acc && pwrite && paddr inside {12'h1E4, 12'h1E8, 12'h1EC, 12'h1F0})
			cfg[paddr[3:2] - 2'h1] <= pwdata[7:0];
	end
	property p_pass; smp_valid && pass_a |-> ##10 out_a_valid && out_a_data == $past(smp_data, 10); endproperty
	a_pass: assert property (p_pass)
		else $error("bypassed sample lost or altered");
	property p_single_b; !dual |-> !out_b_valid; endproperty
	a_single_b: assert property (p_single_b)
		else $error("channel B output in single mode");
	property p_dual_b; smp_valid && smp_chan && dpass |-> ##10 out_b_valid && out_b_data == $past(smp_data, 10);
	endproperty
	a_dual_b: assert property (p_dual_b)
		else $error("second channel sample not on B");
	property p_dual_a; smp_valid && !smp_chan && dpass |-> ##10 out_a_valid && !out_b_valid; endproperty
	a_dual_a: assert property (p_dual_a)
		else $error("first channel sample not on A");
	property p_q11; q_a && cfg[1][1:0] == 2'b01 |-> out_a_data[4:0] == 5'h00; endproperty
	a_q11: assert property (p_q11)
		else $error("11-bit word has low bits set");
	property p_q12; q_a && cfg[1][1] |-> out_a_data[3:0] == 4'h0; endproperty
	a_q12: assert property (p_q12)
		else $error("12-bit word has low bits set");
	property p_half; one_st && out_a_valid |=> !out_a_valid; endproperty
	a_half: assert property (p_half)
		else $error("halving stage gave two outputs in a row");
	property p_map; acc |-> pslverr == !(paddr inside {12'h1E0, 12'h1E4, 12'h1E8, 12'h1EC, 12'h1F0, 12'h1F4});
	endproperty
	a_map: assert property (p_map)
		else $error("error response wrong for address");
	property p_clr_rd; acc && !pwrite && paddr == 12'h1E0 |-> !prdata[7]; endproperty
	a_clr_rd: assert property (p_clr_rd)
		else $error("state clear bit reads back set");
	c_one: cover property (one_st && out_a_valid);
	c_dual: cover property (dual && out_b_valid);
	c_err: cover property (acc && pslverr);
endmodule
bind nsd_top nsd_top_asserts #(.DATA_W(DATA_W)) nsd_top_asserts_inst (.*);

// [tb/testbench.sv]
/* Self-checking bench for nsd_top over APB and the sample stream.
 Assumes nsd_adc_model as the conversion core. */
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [11:0] wa;
		logic [7:0]  wd;
		logic [11:0] ra;
		logic [7:0]  rd;
		logic        er;
	} nsd_row_t;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic               smp_valid, smp_chan, out_a_valid, out_b_valid, start, dual, slow, busy;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, r;
	logic [10:0]        count;
	logic [8:0]         fir;
	logic signed [15:0] smp_data, out_a_data, out_b_data;
	logic signed [15:0] qa[$], qb[$];
	int                 failures, num_checks;
	int                 ks[3] = '{1, 3, 9};
	logic [11:0]        zadr[5] = '{12'h1E0, 12'h1E4, 12'h1E8, 12'h1EC, 12'h1F0};
	logic [7:0]         ms[2] = '{8'h01, 8'h02};
	logic [7:0]         tw[2] = '{8'h0A, 8'h32};
	logic [15:0]        lm[2] = '{16'h001F, 16'h000F};
	nsd_row_t           rows[13];
	nsd_top nsd_top_inst (.*);
	nsd_adc_model nsd_adc_model_inst (.*);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (out_a_valid === 1'b1) qa.push_back(out_a_data);
		if (out_b_valid === 1'b1) qb.push_back(out_b_data);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic stream(input logic d, input logic s, input int n);
		@(posedge pclk);
		start <= 1'b1;
		dual <= d;
		slow <= s;
		count <= 11'(n);
		@(posedge pclk);
		start <= 1'b0;
		do begin
			@(posedge pclk);
		end while (busy === 1'b1);
		// Worst path latency is ten cycles
		repeat (12) @(posedge pclk);
	endtask
	function automatic logic [31:0] ev(input int j, input int k);
		return 32'(16 * (j << k) + 8 * ((1 << k) - 1));
	endfunction
	task automatic cmpq(input int k, input int na, input int nb);
		chk(qa.size(), na);
		chk(qb.size(), nb);
		foreach (qa[j]) chk(qa[j], ev(j, k));
		foreach (qb[j]) chk(qb[j], -ev(j, k));
		qa.delete();
		qb.delete();
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		end_sim();
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, start, dual, slow, count} = '0;
		rows = '{'{12'h1E0, 8'hAA, 12'h1E0, 8'h2A, 1'b0}, '{12'h1E4, 8'h4C, 12'h1E4, 8'h4C, 1'b0},
			'{12'h1EC, 8'h0F, 12'h1EC, 8'h0F, 1'b0}, '{12'h1F0, 8'h0F, 12'h1F0, 8'h0F, 1'b0},
			'{12'h1E8, 8'h82, 12'h1E8, 8'h82, 1'b0}, '{12'h1F4, 8'hFF, 12'h1F4, 8'h05, 1'b0},
			'{12'h1E8, 8'h81, 12'h1F4, 8'h15, 1'b0}, '{12'h1E0, 8'h29, 12'h1F4, 8'h05, 1'b0},
			'{12'h1E8, 8'h83, 12'h1F4, 8'h15, 1'b0}, '{12'h1E4, 8'hCC, 12'h1F4, 8'h94, 1'b0},
			'{12'h1F0, 8'h07, 12'h1F4, 8'hD4, 1'b0}, '{12'h1F8, 8'h11, 12'h1F8, 8'h00, 1'b1},
			'{12'h1E2, 8'h11, 12'h1E2, 8'h00, 1'b1}};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].wa, rows[i].wd);
			apb(1'b0, rows[i].ra, 8'h00);
			chk(r, {24'h000000, rows[i].rd});
			chk({31'h0, e}, {31'h0, rows[i].er});
		end
		$display("test registers done");
		foreach (zadr[i]) apb(1'b1, zadr[i], 8'h00);
		stream(1'b0, 1'b0, 16);
		cmpq(0, 16, 0);
		$display("test bypass done");
		foreach (ks[i]) begin
			fir = 9'((1 << ks[i]) - 1);
			apb(1'b1, 12'h1E8, {fir[0], 7'h00});
			apb(1'b1, 12'h1EC, fir[8:1]);
			stream(1'b0, ks[i] == 3, 2 << ks[i]);
			cmpq(ks[i], 2, 0);
		end
		$display("test decimation done");
		apb(1'b1, 12'h1E8, 8'h00);
		apb(1'b1, 12'h1EC, 8'h00);
		apb(1'b1, 12'h1E4, 8'h80);
		stream(1'b1, 1'b0, 8);
		cmpq(0, 4, 4);
		apb(1'b1, 12'h1EC, 8'hFF);
		apb(1'b1, 12'h1F0, 8'hFF);
		stream(1'b1, 1'b0, 1024);
		cmpq(8, 2, 2);
		$display("test dual done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		foreach (zadr[i]) begin
			apb(1'b0, zadr[i], 8'h00);
			chk(r, 32'h0);
		end
		$display("test reset done");
		foreach (ms[i]) begin
			apb(1'b1, 12'h1E8, ms[i]);
			apb(1'b1, 12'h1E0, tw[i] | 8'h80);
			stream(1'b0, 1'b0, 16);
			chk(qa.size(), 16);
			foreach (qa[j]) chk(qa[j] & lm[i], 32'h0);
			qa.delete();
		end
		// Second requantizer, only reachable in dual mode
		apb(1'b1, 12'h1E4, 8'hB2);
		apb(1'b1, 12'h1E8, 8'h08);
		apb(1'b1, 12'h1E0, 8'h80);
		stream(1'b1, 1'b0, 16);
		chk(qa.size(), 8);
		chk(qb.size(), 8);
		foreach (qa[j]) chk(qa[j], ev(j, 0));
		foreach (qb[j]) chk(qb[j] & 16'h000F, 32'h0);
		qa.delete();
		qb.delete();
		$display("test requantizer done");
		end_sim();
	end
endmodule
